/* File: fwr_top.sv */
`timescale 1ns/1ps
`include "fwr_defs.svh"
// Contract
// - Alert pin low on overheat, overcurrent, DC detect
// - Masks block alert pin only, nothing else
// - Software may add more alert pin sources
// - Power-down low holds everything off, registers reset
// - Standby low: core-only, outputs off, registers kept
// - Two general pins, unused until host configures
// - Pin acts as input once input function set
// - Pin outputs the function code host wrote
// - Ramp clock out on pin, spread when enabled
// - Switching clock locks to pin sync or bitclock
// - Fault signal selectable from nine categories
// - Fault signal drives alert pin, optionally general pins
// - Any-error flag set by any active fault
// - Configured-error flag only for selected faults
// - Warning signal selectable from eight categories
// - Warning signal reaches no pin after reset
// - Any-alert flag for any warning except clock
// - Configured-alert flag only for selected warnings
// - Channel states gate output stage and DSP
// - Power-down release restarts device with defaults
// - Supply under/overvoltage forces protective shutdown
// - Core supply power-on-reset low shuts device down
// - Output_active_state request moves high-impedance channel to active
// - Self-recover channel resumes once cause clears
module fwr_top
    import fwr_pkg::*;
(
    // Clock and reset
    input  logic                   clk,
    input  logic                   srst,
    // Device control pins and supply monitors
    input  logic                   power_down_pin_n,
    input  logic                   low_power_hold_pin_n,
    input  logic                   core_por_low,
    input  logic                   bat_uv,
    input  logic                   bat_ov,
    input  logic                   pstage_uv,
    input  logic                   pstage_ov,
    input  logic                   core_uv,
    input  logic                   cp_uv,
    input  logic                   cp_ov,
    // Protection events
    input  logic                   overheat_shutdown,
    input  logic [3:0]             ch_overheat_shutdown,
    input  logic                   overheat_warning,
    input  logic [3:0]             overcurrent_limit,
    input  logic [3:0]             overcurrent_cutoff,
    input  logic [3:0]             dc_detect,
    input  logic                   dc_load_check_fault,
    input  logic [3:0]             rt_diag_fault,
    input  logic                   clock_error,
    input  logic                   charge_pump_fault,
    input  logic                   clip_detect,
    // Latch clears, one-cycle pulses
    input  logic                   clr_power,
    input  logic                   clr_overheat,
    input  logic                   clr_warning,
    input  logic [3:0]             clr_overcurrent,
    input  logic [3:0]             clr_dc_detect,
    input  logic [3:0]             clr_rt_diag,
    input  logic                   clr_clock,
    input  logic                   clr_charge_pump,
    input  logic                   clr_clip,
    // Configuration, loaded on cfg_wr; state_req acts directly
    input  logic                   cfg_wr,
    input  logic [8:0]             cfg_fault_en,
    input  logic [8:0]             cfg_fault_pin_mask,
    input  logic [7:0]             cfg_warn_en,
    input  logic                   cfg_warn_to_alert,
    input  logic                   cfg_heat_selfrec,
    input  logic                   cfg_spread_en,
    input  fwr_pkg::fwr_sync_t     cfg_sync_src,
    input  fwr_pkg::fwr_gpo_t      cfg_gpo0,
    input  fwr_pkg::fwr_gpo_t      cfg_gpo1,
    input  fwr_pkg::fwr_gpi_t      cfg_gpi0,
    input  fwr_pkg::fwr_gpi_t      cfg_gpi1,
    input  fwr_pkg::fwr_req_t      state_req,
    // Clocks
    input  logic                   ramp_clk,
    input  logic                   spread_ramp_clk,
    input  logic                   serial_bit_clk,
    output logic                   switch_clk_ref,
    // Alert pin, open drain
    output logic                   error_alert_o,
    output logic                   error_alert_oe_n,
    // General pins
    input  logic [1:0]             gpio_i,
    output logic [1:0]             gpio_o,
    output logic [1:0]             gpio_oe_n,
    // Report bits and states
    output logic                   any_error_flag,
    output logic                   configured_error_flag,
    output logic                   any_alert_flag,
    output logic                   configured_alert_flag,
    output fwr_pkg::fwr_dev_state_t dev_state,
    output fwr_pkg::fwr_ch_state_t ch_state [4],
    output logic [3:0]             ch_fets_on,
    output logic [3:0]             ch_dsp_on,
    output logic                   analog_bias_on
);
    function automatic logic [3:0] sticky(input logic [3:0] lat, input logic [3:0] set, input logic [3:0] clr);
        sticky = set | (lat & ~clr);
    endfunction

    // Internal reset covers every register: strap-free shutdown and restart
    logic rst_int;
    assign rst_int = srst || !power_down_pin_n || core_por_low;

    // Configuration registers
    logic [8:0] fault_en;
    logic [8:0] fault_pin_mask;
    logic [7:0] warn_en;
    logic       warn_to_alert;
    logic       heat_selfrec;
    logic       spread_en;
    fwr_sync_t  sync_src;
    fwr_gpo_t   gpo0;
    fwr_gpo_t   gpo1;
    fwr_gpi_t   gpi0;
    fwr_gpi_t   gpi1;

    always_ff @(posedge clk) begin
        if (rst_int) begin
            fault_en <= `FWR_FLT_EN_RST;
            fault_pin_mask <= `FWR_FLT_MSK_RST;
            warn_en <= `FWR_WRN_EN_RST;
            warn_to_alert <= 1'b0;
            heat_selfrec <= 1'b0;
            spread_en <= 1'b0;
            sync_src <= SYNC_INTERNAL;
            gpo0 <= GPO_OFF;
            gpo1 <= GPO_OFF;
            gpi0 <= GPI_NONE;
            gpi1 <= GPI_NONE;
        end else if (cfg_wr) begin
            fault_en <= cfg_fault_en;
            fault_pin_mask <= cfg_fault_pin_mask;
            warn_en <= cfg_warn_en;
            warn_to_alert <= cfg_warn_to_alert;
            heat_selfrec <= cfg_heat_selfrec;
            spread_en <= cfg_spread_en;
            sync_src <= cfg_sync_src;
            gpo0 <= cfg_gpo0;
            gpo1 <= cfg_gpo1;
            gpi0 <= cfg_gpi0;
            gpi1 <= cfg_gpi1;
        end
    end

    // Event latches; a set in the clear cycle wins
    logic       power_raw;
    logic       power_lat;
    logic       heat_lat;
    logic       warm_lat;
    logic [3:0] oclim_lat;
    logic [3:0] ocut_lat;
    logic [3:0] dcdet_lat;
    logic [3:0] rtld_lat;
    logic       clk_lat;
    logic       cp_lat;
    logic       clip_lat;
    logic       heat_any;

    assign power_raw = bat_uv | bat_ov | pstage_uv | pstage_ov | core_uv | cp_uv | cp_ov;
    assign heat_any  = overheat_shutdown | (|ch_overheat_shutdown);

    always_ff @(posedge clk) begin
        if (rst_int) begin
            power_lat <= 1'b0;
            heat_lat <= 1'b0;
            warm_lat <= 1'b0;
            oclim_lat <= 4'h0;
            ocut_lat <= 4'h0;
            dcdet_lat <= 4'h0;
            rtld_lat <= 4'h0;
            clk_lat <= 1'b0;
            cp_lat <= 1'b0;
            clip_lat <= 1'b0;
        end else begin
            power_lat <= power_raw | (power_lat & ~clr_power);
            heat_lat <= heat_any | (heat_lat & ~clr_overheat);
            warm_lat <= overheat_warning | (warm_lat & ~clr_warning);
            oclim_lat <= sticky(oclim_lat, overcurrent_limit, clr_overcurrent);
            ocut_lat <= sticky(ocut_lat, overcurrent_cutoff, clr_overcurrent);
            dcdet_lat <= sticky(dcdet_lat, dc_detect, clr_dc_detect);
            rtld_lat <= sticky(rtld_lat, rt_diag_fault, clr_rt_diag);
            clk_lat <= clock_error | (clk_lat & ~clr_clock);
            cp_lat <= charge_pump_fault | (cp_lat & ~clr_charge_pump);
            clip_lat <= clip_detect | (clip_lat & ~clr_clip);
        end
    end

    // Device level state
    fwr_dev_state_t next_dev_state;
    logic           dev_run;

    assign next_dev_state = !low_power_hold_pin_n ? DEV_CORE_ONLY : DEV_ACTIVE;
    assign dev_run = (dev_state == DEV_ACTIVE);

    always_ff @(posedge clk) begin
        if (rst_int) begin
            dev_state <= DEV_SHUTDOWN;
            analog_bias_on <= 1'b0;
        end else begin
            dev_state <= next_dev_state;
            analog_bias_on <= (next_dev_state == DEV_ACTIVE);
        end
    end

    // Channel states
    logic [3:0] ch_fault;
    logic [3:0] ch_recover;
    logic       global_fault;
    logic       global_recover;
    logic [3:0] ch_in_fault;

    // Clock errors and supply faults are self-clearing, so they recover rather than latch
    assign global_recover = power_raw | clock_error | (overheat_shutdown & heat_selfrec);
    assign global_fault   = charge_pump_fault | cp_lat | (overheat_shutdown & ~heat_selfrec);

    genvar g;
    generate
        for (g = 0; g < `FWR_NCH; g = g + 1) begin : g_ch
            assign ch_fault[g] = global_fault | ocut_lat[g] | dcdet_lat[g] | rtld_lat[g]
                               | (ch_overheat_shutdown[g] & ~heat_selfrec);
            assign ch_recover[g] = global_recover | (ch_overheat_shutdown[g] & heat_selfrec);
            assign ch_in_fault[g] = (ch_state[g] == CH_FAULT);

            fwr_chan_fsm u_chan (
                .clk           (clk),
                .srst          (rst_int),
                .dev_run       (dev_run),
                .req           (state_req),
                .clk_err       (clock_error),
                .ch_fault      (ch_fault[g]),
                .recover_cause (ch_recover[g]),
                .state         (ch_state[g]),
                .fets_on       (ch_fets_on[g]),
                .dsp_on        (ch_dsp_on[g])
            );
        end
    endgenerate

    // Fault and warning categories
    logic [8:0] fault_terms;
    logic [7:0] warn_terms;
    logic       fault_sig;
    logic       warn_sig;
    logic       alert_assert;

    assign fault_terms[`FWR_F_PWR]   = power_raw | power_lat;
    assign fault_terms[`FWR_F_HEAT]  = heat_any | heat_lat;
    assign fault_terms[`FWR_F_DCLD]  = dc_load_check_fault;
    assign fault_terms[`FWR_F_OC]    = |(oclim_lat | ocut_lat);
    assign fault_terms[`FWR_F_DCDET] = |dcdet_lat;
    assign fault_terms[`FWR_F_CHFLT] = |ch_in_fault;
    assign fault_terms[`FWR_F_RTLD]  = |rtld_lat;
    assign fault_terms[`FWR_F_CLK]   = clk_lat;
    assign fault_terms[`FWR_F_CP]    = cp_lat;

    assign warn_terms[`FWR_W_PWR]    = power_raw | power_lat;
    assign warn_terms[`FWR_W_HEAT]   = heat_any | heat_lat;
    assign warn_terms[`FWR_W_WARM]   = overheat_warning | warm_lat;
    assign warn_terms[`FWR_W_DCLD]   = dc_load_check_fault;
    assign warn_terms[`FWR_W_OCLIM]  = |(overcurrent_limit | oclim_lat);
    assign warn_terms[`FWR_W_CLIP]   = clip_detect | clip_lat;
    assign warn_terms[`FWR_W_RTLD]   = |rtld_lat;
    assign warn_terms[`FWR_W_CLK]    = clk_lat;

    assign fault_sig = |(fault_terms & fault_en);
    assign warn_sig  = |(warn_terms & warn_en);
    // Mask acts only here; latches, flags and channel actions never see it
    assign alert_assert = |(fault_terms & fault_en & ~fault_pin_mask)
                        | (warn_to_alert & warn_sig);

    always_ff @(posedge clk) begin
        if (rst_int) begin
            any_error_flag <= 1'b0;
            configured_error_flag <= 1'b0;
            any_alert_flag <= 1'b0;
            configured_alert_flag <= 1'b0;
            error_alert_oe_n <= 1'b1;
        end else begin
            any_error_flag <= |fault_terms;
            configured_error_flag <= fault_sig;
            any_alert_flag <= |warn_terms[6:0];
            configured_alert_flag <= warn_sig;
            error_alert_oe_n <= !alert_assert;
        end
    end

    assign error_alert_o = 1'b0;

    // Clock sharing and synchronisation
    logic       ramp_out;
    logic [1:0] gpio_sync;
    logic       gpio_sync_any;

    assign ramp_out = spread_en ? spread_ramp_clk : ramp_clk;
    assign gpio_sync_any = |gpio_sync;

    always_ff @(posedge clk) begin
        if (rst_int) begin
            switch_clk_ref <= 1'b0;
        end else begin
            case (sync_src)
                SYNC_GPIO:   switch_clk_ref <= gpio_sync_any;
                SYNC_BITCLK: switch_clk_ref <= serial_bit_clk;
                default:     switch_clk_ref <= ramp_clk;
            endcase
        end
    end

    // General pins; released while the device is not fully active
    fwr_gpio_pin u_gpio0 (
        .clk         (clk),
        .srst        (rst_int),
        .out_func    (gpo0),
        .in_func     (gpi0),
        .outputs_off (!dev_run),
        .fault_sig   (fault_sig),
        .warn_sig    (warn_sig),
        .ramp_clk    (ramp_out),
        .pin_i       (gpio_i[0]),
        .pin_o       (gpio_o[0]),
        .pin_oe_n    (gpio_oe_n[0]),
        .sync_in     (gpio_sync[0])
    );

    fwr_gpio_pin u_gpio1 (
        .clk         (clk),
        .srst        (rst_int),
        .out_func    (gpo1),
        .in_func     (gpi1),
        .outputs_off (!dev_run),
        .fault_sig   (fault_sig),
        .warn_sig    (warn_sig),
        .ramp_clk    (ramp_out),
        .pin_i       (gpio_i[1]),
        .pin_o       (gpio_o[1]),
        .pin_oe_n    (gpio_oe_n[1]),
        .sync_in     (gpio_sync[1])
    );
endmodule

/* File: fwr_defs.svh */
`ifndef FWR_DEFS_SVH
`define FWR_DEFS_SVH

// Channel count and category vector widths
`define FWR_NCH         4
`define FWR_NFLT        9
`define FWR_NWRN        8

// Fault signal source positions
`define FWR_F_PWR       0
`define FWR_F_HEAT      1
`define FWR_F_DCLD      2
`define FWR_F_OC        3
`define FWR_F_DCDET     4
`define FWR_F_CHFLT     5
`define FWR_F_RTLD      6
`define FWR_F_CLK       7
`define FWR_F_CP        8

// Warning signal source positions
`define FWR_W_PWR       0
`define FWR_W_HEAT      1
`define FWR_W_WARM      2
`define FWR_W_DCLD      3
`define FWR_W_OCLIM     4
`define FWR_W_CLIP      5
`define FWR_W_RTLD      6
`define FWR_W_CLK       7

// Reset values of the configuration registers
`define FWR_FLT_EN_RST  9'h01A
`define FWR_FLT_MSK_RST 9'h000
`define FWR_WRN_EN_RST  8'h00

`endif

/* File: fwr_pkg.sv */
package fwr_pkg;
    typedef enum logic [2:0] {CH_SLEEP, CH_HIZ, CH_OUTPUT_ACTIVE_STATE, CH_FAULT, CH_SELF_RECOVER} fwr_ch_state_t;
    typedef enum logic [1:0] {DEV_SHUTDOWN, DEV_CORE_ONLY, DEV_ACTIVE} fwr_dev_state_t;
    typedef enum logic [1:0] {REQ_SLEEP, REQ_HIZ, REQ_OUTPUT_ACTIVE_STATE} fwr_req_t;
    typedef enum logic [2:0] {GPO_OFF, GPO_FAULT, GPO_WARN, GPO_RAMP_CLK, GPO_LOW, GPO_HIGH} fwr_gpo_t;
    typedef enum logic [1:0] {GPI_NONE, GPI_SYNC} fwr_gpi_t;
    typedef enum logic [1:0] {SYNC_INTERNAL, SYNC_GPIO, SYNC_BITCLK} fwr_sync_t;
endpackage

/* File: fwr_chan_fsm.sv */
`timescale 1ns/1ps
module fwr_chan_fsm
    import fwr_pkg::*;
(
    // Clock and reset
    input  logic                   clk,
    input  logic                   srst,
    // Conditions
    input  logic                   dev_run,
    input  fwr_pkg::fwr_req_t      req,
    input  logic                   clk_err,
    input  logic                   ch_fault,
    input  logic                   recover_cause,
    // State
    output fwr_pkg::fwr_ch_state_t state,
    output logic                   fets_on,
    output logic                   dsp_on
);
    fwr_ch_state_t next_state;
    logic          resume_output_active_state;
    logic          next_resume_output_active_state;

    always_comb begin
        next_state = state;
        next_resume_output_active_state = resume_output_active_state;
        case (state)
            CH_SLEEP: begin
                if (req != REQ_SLEEP && !clk_err) begin
                    next_state = CH_HIZ;
                end
            end
            CH_HIZ, CH_OUTPUT_ACTIVE_STATE: begin
                if (recover_cause) begin
                    next_state = CH_SELF_RECOVER;
                    next_resume_output_active_state = (state == CH_OUTPUT_ACTIVE_STATE);
                end else if (ch_fault) begin
                    next_state = CH_FAULT;
                end else if (req == REQ_SLEEP) begin
                    next_state = CH_SLEEP;
                end else if (req == REQ_OUTPUT_ACTIVE_STATE) begin
                    next_state = CH_OUTPUT_ACTIVE_STATE;
                end else begin
                    next_state = CH_HIZ;
                end
            end
            CH_FAULT: begin
                // Software leaves a latched fault by asking for sleep once ch_fault has cleared, as does leaving DEV_ACTIVE
                if (req == REQ_SLEEP && !ch_fault) begin
                    next_state = CH_SLEEP;
                end
            end
            CH_SELF_RECOVER: begin
                if (!recover_cause) begin
                    next_state = resume_output_active_state ? CH_OUTPUT_ACTIVE_STATE : CH_HIZ;
                end
            end
            default: next_state = CH_SLEEP;
        endcase
        if (!dev_run) begin
            next_state = CH_SLEEP;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= CH_SLEEP;
            resume_output_active_state <= 1'b0;
        end else begin
            state <= next_state;
            resume_output_active_state <= next_resume_output_active_state;
        end
    end

    assign fets_on = (state == CH_OUTPUT_ACTIVE_STATE);
    assign dsp_on  = (state == CH_OUTPUT_ACTIVE_STATE) || (state == CH_HIZ);
endmodule

/* File: fwr_gpio_pin.sv */
`timescale 1ns/1ps
module fwr_gpio_pin
    import fwr_pkg::*;
(
    // Clock and reset
    input  logic              clk,
    input  logic              srst,
    // Configuration
    input  fwr_pkg::fwr_gpo_t out_func,
    input  fwr_pkg::fwr_gpi_t in_func,
    input  logic              outputs_off,
    // Internal signals offered to the pin
    input  logic              fault_sig,
    input  logic              warn_sig,
    input  logic              ramp_clk,
    // Pin
    input  logic              pin_i,
    output logic              pin_o,
    output logic              pin_oe_n,
    output logic              sync_in
);
    logic drive;
    logic level;

    assign drive = (out_func != GPO_OFF) && (in_func == GPI_NONE) && !outputs_off;
    assign level = (out_func == GPO_FAULT)    ? fault_sig :
                   (out_func == GPO_WARN)     ? warn_sig :
                   (out_func == GPO_RAMP_CLK) ? ramp_clk :
                   (out_func == GPO_HIGH);

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_o <= 1'b0;
            pin_oe_n <= 1'b1;
            sync_in <= 1'b0;
        end else begin
            pin_o <= level;
            pin_oe_n <= !drive;
            sync_in <= (in_func == GPI_SYNC) && pin_i;
        end
    end
endmodule

/* File: fwr_top_asserts.sv */
`timescale 1ns/1ps
module fwr_top_asserts
    import fwr_pkg::*;
(
    // Clock and reset
    input  logic                    clk,
    input  logic                    srst,
    // Watched inputs
    input  logic                    power_down_pin_n,
    input  logic                    low_power_hold_pin_n,
    input  logic                    core_por_low,
    input  logic [3:0]              overcurrent_cutoff,
    input  logic                    cfg_wr,
    // Watched outputs
    input  logic                    error_alert_o,
    input  logic                    error_alert_oe_n,
    input  logic [1:0]              gpio_oe_n,
    input  logic                    any_error_flag,
    input  logic                    configured_error_flag,
    input  logic                    any_alert_flag,
    input  fwr_pkg::fwr_dev_state_t dev_state,
    input  logic [3:0]              ch_fets_on,
    input  logic                    analog_bias_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire run_ok = power_down_pin_n && !core_por_low;
    // Set by the first configuration load since any reset
    logic cfg_seen;
    always_ff @(posedge clk) begin
        if (srst || !run_ok) begin
            cfg_seen <= 1'b0;
        end else begin
            cfg_seen <= cfg_seen || cfg_wr;
        end
    end
    sequence oc_seq;
        run_ok && (overcurrent_cutoff != 4'h0) ##1 run_ok;
    endsequence
    sequence hold_seq;
        run_ok && !low_power_hold_pin_n ##1 run_ok && !low_power_hold_pin_n;
    endsequence
    pwrdn_reset_a: assert property (!power_down_pin_n |=> dev_state == DEV_SHUTDOWN && ch_fets_on == 4'h0
        && !any_error_flag) else $error("power-down did not hold device off");
    por_down_a: assert property (core_por_low |=> dev_state == DEV_SHUTDOWN)
        else $error("core supply low did not shut down");
    oc_flag_a: assert property (oc_seq |-> ##[0:1] any_error_flag)
        else $error("cutoff event not reported");
    hold_bias_a: assert property (hold_seq |-> ##1 !analog_bias_on && ch_fets_on == 4'h0)
        else $error("standby left bias or outputs on");
    pwrdn_release_a: assert property ($rose(power_down_pin_n) |-> error_alert_oe_n && gpio_oe_n == 2'h3)
        else $error("pins not at defaults after power-down");
    alert_cause_a: assert property (!error_alert_oe_n |-> !error_alert_o && (any_error_flag || any_alert_flag))
        else $error("alert pin low without cause");
    cfg_flag_a: assert property (configured_error_flag |-> any_error_flag)
        else $error("configured error without any error");
    gpio_idle_a: assert property (!cfg_seen |-> gpio_oe_n == 2'h3)
        else $error("general pin driven without configuration");
endmodule
bind fwr_top fwr_top_asserts fwr_top_asserts_inst (.*);

/* File: fwr_host.sv */
`timescale 1ns/1ps
module fwr_host
    import fwr_pkg::*;
(
    // Device pins
    input  logic       error_alert_o,
    input  logic       error_alert_oe_n,
    input  logic [1:0] gpio_o,
    input  logic [1:0] gpio_oe_n,
    // Host side
    input  logic [1:0] ext_sync,
    output logic       alert_level,
    output logic [1:0] gpio_i
);
    // Pull-up holds the shared alert line high when released
    assign alert_level = error_alert_oe_n ? 1'b1 : error_alert_o;
    // Host drives a pin only while the device has let go of it
    assign gpio_i = (gpio_oe_n & ext_sync) | (~gpio_oe_n & gpio_o);
endmodule

/* File: fwr_top_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module fwr_top_tb;
    import fwr_pkg::*;
    logic       clk, srst, power_down_pin_n, low_power_hold_pin_n, core_por_low, bat_uv, bat_ov, pstage_uv, pstage_ov;
    logic       core_uv, cp_uv, cp_ov, overheat_shutdown, overheat_warning, dc_load_check_fault, clock_error;
    logic       charge_pump_fault, clip_detect, clr_power, clr_overheat, clr_warning, clr_clock, clr_charge_pump;
    logic       clr_clip, cfg_wr, cfg_warn_to_alert, cfg_heat_selfrec, cfg_spread_en, ramp_clk, spread_ramp_clk;
    logic       serial_bit_clk, switch_clk_ref, error_alert_o, error_alert_oe_n, alert, any_error_flag;
    logic       configured_error_flag, any_alert_flag, configured_alert_flag, analog_bias_on;
    logic [3:0] ch_overheat_shutdown, overcurrent_limit, overcurrent_cutoff, dc_detect, rt_diag_fault;
    logic [3:0] clr_overcurrent, clr_dc_detect, clr_rt_diag, ch_fets_on, ch_dsp_on;
    logic [8:0] cfg_fault_en, cfg_fault_pin_mask;
    logic [7:0] cfg_warn_en;
    logic [1:0] gpio_i, gpio_o, gpio_oe_n, ext_sync;
    fwr_sync_t  cfg_sync_src;
    fwr_gpo_t   cfg_gpo0, cfg_gpo1;
    fwr_gpi_t   cfg_gpi0, cfg_gpi1;
    fwr_req_t   state_req;
    fwr_dev_state_t dev_state;
    fwr_ch_state_t  ch_state [4];
    int         error_cnt, n_tests, cyc;
    fwr_top fwr_top_inst (.*);
    fwr_host fwr_host_inst (.alert_level(alert), .*);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr;
        cfg_wr = 1'b1;
        w(1);
        cfg_wr = 1'b0;
        w(2);
    endtask
    task automatic clr;
        {clr_power, clr_overheat, clr_warning, clr_clock, clr_charge_pump, clr_clip} = '1;
        {clr_overcurrent, clr_dc_detect, clr_rt_diag} = '1;
        w(1);
        {clr_power, clr_overheat, clr_warning, clr_clock, clr_charge_pump, clr_clip} = '0;
        {clr_overcurrent, clr_dc_detect, clr_rt_diag} = '0;
        w(2);
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test;
        end
    end
    initial begin
        {core_por_low, bat_uv, bat_ov, pstage_uv, pstage_ov, core_uv, cp_uv, cp_ov, overheat_shutdown} = '0;
        {overheat_warning, dc_load_check_fault, clock_error, charge_pump_fault, clip_detect, cfg_wr} = '0;
        {cfg_warn_to_alert, cfg_heat_selfrec, cfg_spread_en, ramp_clk, spread_ramp_clk, serial_bit_clk} = '0;
        {ch_overheat_shutdown, overcurrent_limit, overcurrent_cutoff, dc_detect, rt_diag_fault, ext_sync} = '0;
        {clr_power, clr_overheat, clr_warning, clr_clock, clr_charge_pump, clr_clip} = '0;
        {clr_overcurrent, clr_dc_detect, clr_rt_diag, cfg_fault_pin_mask, cfg_warn_en} = '0;
        {power_down_pin_n, low_power_hold_pin_n, srst} = 3'h7;
        cfg_fault_en = 9'h01A;
        {cfg_gpo0, cfg_gpo1, cfg_gpi0, cfg_gpi1} = {GPO_OFF, GPO_OFF, GPI_NONE, GPI_NONE};
        cfg_sync_src = SYNC_INTERNAL;
        state_req = REQ_SLEEP;
        w(4);
        srst = 1'b0;
        w(2);
        `CHK({dev_state, alert, gpio_oe_n}, {DEV_ACTIVE, 3'h7})
        state_req = REQ_OUTPUT_ACTIVE_STATE;
        w(3);
        `CHK({ch_fets_on, ch_dsp_on}, 8'hFF)
        bat_uv = 1'b1;
        w(3);
        `CHK({ch_state[0], ch_fets_on, alert, any_error_flag}, {CH_SELF_RECOVER, 6'h03})
        bat_uv = 1'b0;
        clr;
        `CHK(ch_state[0], CH_OUTPUT_ACTIVE_STATE)
        overcurrent_cutoff = 4'h1;
        w(1);
        overcurrent_cutoff = 4'h0;
        w(2);
        `CHK({alert, configured_error_flag, ch_fets_on}, 6'h1E)
        clr;
        `CHK(alert, 1'b1)
        cfg_fault_pin_mask = 9'h002;
        wr;
        overheat_shutdown = 1'b1;
        w(3);
        `CHK({alert, configured_error_flag, ch_fets_on}, 6'h30)
        {overheat_shutdown, cfg_fault_pin_mask, cfg_fault_en} = {1'b0, 9'h000, 9'h080};
        clr;
        wr;
        clock_error = 1'b1;
        w(3);
        `CHK({alert, gpio_oe_n}, 3'h3)
        {clock_error, cfg_fault_en, cfg_warn_en, cfg_gpo0, cfg_gpo1} = {1'b0, 9'h01A, 8'h04, GPO_WARN, GPO_FAULT};
        clr;
        wr;
        overheat_warning = 1'b1;
        w(3);
        `CHK({gpio_oe_n, gpio_o, any_alert_flag, configured_alert_flag, alert}, 7'h0F)
        cfg_warn_to_alert = 1'b1;
        wr;
        `CHK(alert, 1'b0)
        {overheat_warning, cfg_warn_to_alert, cfg_warn_en} = {2'h0, 8'h80};
        clr;
        wr;
        clock_error = 1'b1;
        w(3);
        `CHK({any_alert_flag, configured_alert_flag}, 2'h1)
        clock_error = 1'b0;
        clr;
        overheat_shutdown = 1'b1;
        w(3);
        `CHK({gpio_o[1], alert}, 2'h2)
        {overheat_shutdown, cfg_gpo0, cfg_gpo1, cfg_gpi1} = {1'b0, GPO_RAMP_CLK, GPO_OFF, GPI_SYNC};
        clr;
        cfg_sync_src = SYNC_GPIO;
        wr;
        {ext_sync, ramp_clk} = 3'h5;
        w(2);
        `CHK({gpio_o[0], gpio_oe_n}, 3'h6)
        ramp_clk = 1'b0;
        w(2);
        `CHK({gpio_o[0], switch_clk_ref}, 2'h1)
        ext_sync = 2'h0;
        w(3);
        `CHK(switch_clk_ref, 1'b0)
        cfg_spread_en = 1'b1;
        wr;
        spread_ramp_clk = 1'b1;
        w(2);
        `CHK(gpio_o[0], 1'b1)
        cfg_sync_src = SYNC_BITCLK;
        wr;
        serial_bit_clk = 1'b1;
        w(3);
        `CHK(switch_clk_ref, 1'b1)
        low_power_hold_pin_n = 1'b0;
        w(3);
        `CHK({dev_state, analog_bias_on, gpio_oe_n}, {DEV_CORE_ONLY, 3'h3})
        low_power_hold_pin_n = 1'b1;
        w(3);
        `CHK(gpio_oe_n, 2'h2)
        power_down_pin_n = 1'b0;
        w(2);
        `CHK(dev_state, DEV_SHUTDOWN)
        power_down_pin_n = 1'b1;
        w(3);
        `CHK(gpio_oe_n, 2'h3)
        core_por_low = 1'b1;
        w(2);
        `CHK(dev_state, DEV_SHUTDOWN)
        core_por_low = 1'b0;
        w(2);
        {cfg_heat_selfrec, cfg_gpo1, cfg_gpi1} = {1'b1, GPO_HIGH, GPI_NONE};
        wr;
        overheat_shutdown = 1'b1;
        w(2);
        `CHK({ch_state[1], gpio_o[1]}, {CH_SELF_RECOVER, 1'b1})
        overheat_shutdown = 1'b0;
        w(2);
        `CHK(ch_state[1], CH_OUTPUT_ACTIVE_STATE)
        finish_test;
    end
endmodule
